// *** common/io_bus_pkg.sv ***
// shared constants for the io cycle request/grant link and its two ends
package io_bus_pkg;
   // data path and decode widths
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned BANK_W   = 3;
   localparam int unsigned INDEX_W  = 5;
   localparam int unsigned SELECTS  = 7;
   // cycle speed type codes
   localparam logic [1:0] TYPE_SLOW   = 2'h0;
   localparam logic [1:0] TYPE_MEDIUM = 2'h1;
   localparam logic [1:0] TYPE_FAST   = 2'h2;
   localparam logic [1:0] TYPE_SYNC   = 2'h3;
   // bank zero means the block's own registers
   localparam logic [2:0] BANK_INTERNAL = 3'h0;
   // direction codes
   localparam logic DIR_READ  = 1'b0;
   localparam logic DIR_WRITE = 1'b1;
   // clock and strobe timing
   localparam int unsigned REF_CLK_HZ  = 25_000_000;
   localparam int unsigned CLK_DIV     = 4;
   localparam int unsigned WAIT_W      = 4;
   localparam logic [3:0]  WAIT_SLOW   = 4'hB;
   localparam logic [3:0]  WAIT_MEDIUM = 4'h7;
   localparam logic [3:0]  WAIT_FAST   = 4'h3;
   localparam logic [3:0]  WAIT_SYNC   = 4'h1;
   localparam logic [1:0]  DIV_LAST    = 2'h3;
   // reset values
   localparam logic [1:0]  RST_DIV     = 2'h0;
   localparam logic [7:0]  RST_DATA    = 8'h00;
   localparam logic [6:0]  RST_SELECTS = 7'h7F;
   // depth of the read data buffer on the requester side
   localparam int unsigned RSP_DEPTH   = 2;
endpackage

// *** common/io_bus_if.sv ***
// link between the io cycle requester and the io controller
`timescale 1ns/1ps
interface io_bus_if;
   import io_bus_pkg::*;
   logic                io_cycle_request_n;
   logic                io_cycle_grant_n;
   logic [1:0]          cycle_speed_type;
   logic                read_write_n;
   logic                chip_select;
   logic [BANK_W-1:0]   bank_code;
   logic [INDEX_W-1:0]  register_index;
   logic [DATA_W-1:0]   host_data_req;
   logic                host_data_req_oe;
   logic [DATA_W-1:0]   host_data_dev;
   logic                host_data_dev_oe;
   logic [DATA_W-1:0]   host_data;
   // resolved level of the shared data lines; undriven lines float to ones
   assign host_data = host_data_dev_oe ? host_data_dev :
                      host_data_req_oe ? host_data_req : 8'hFF;
   modport device (
      input  io_cycle_request_n, cycle_speed_type, read_write_n, chip_select,
      input  bank_code, register_index, host_data,
      output io_cycle_grant_n, host_data_dev, host_data_dev_oe
   );
   modport requester (
      output io_cycle_request_n, cycle_speed_type, read_write_n, chip_select,
      output bank_code, register_index, host_data_req, host_data_req_oe,
      input  io_cycle_grant_n, host_data
   );
endinterface

// *** hdl/io_cycle_device.sv ***
// io controller end: decodes io cycles to internal registers or peripheral selects
// What this block does
// - peripheral timing clock is reference divided by four
// - buffered system clock is reference inverted
// - latch hold high for internal or deselected
// - latch hold low during external reads, writes
// - drive host data only returning read data
// - respond only while request is low
// - grant low means completion next rising edge
// - cycle ends with grant and request low
// - type code picks slow medium fast synchronous
// - direction low reads, high writes
// - external buffer select during external access
// - bank code picks one peripheral select
// - bank zero internal, nonzero external
// - cycles only with chip select high
// - register index picks internal register
// - read buffer enable low on reads
// - write buffer enable low on writes
// - read strobe times external reads
// - write strobe times external writes
// - banks one to seven map select lines
`timescale 1ns/1ps
module io_cycle_device
   import io_bus_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   // link to the requester
   io_bus_if.device                 bus,
   // peripheral clocks
   output logic                     clk_div4_o,
   output logic                     sys_clk_n_o,
   // buffer and latch controls
   output logic                     data_latch_hold_n_o,
   output logic                     ext_buffer_select_n_o,
   output logic                     read_buffer_en_n_o,
   output logic                     write_buffer_en_n_o,
   // peripheral selects and strobes
   output logic [SELECTS-1:0]       peripheral_select_n_o,
   output logic                     periph_read_strobe_n_o,
   output logic                     periph_write_strobe_n_o,
   // peripheral data lines
   input  wire logic [DATA_W-1:0]   periph_data_i,
   output logic [DATA_W-1:0]        periph_data_o,
   output logic                     periph_data_oe_o,
   // internal register port
   output logic [INDEX_W-1:0]       reg_index_o,
   output logic                     reg_read_o,
   output logic                     reg_write_o,
   output logic [DATA_W-1:0]        reg_wdata_o,
   input  wire logic [DATA_W-1:0]   reg_rdata_i
);
   typedef enum logic [1:0] {ST_IDLE, ST_INT, ST_EXT, ST_GRANT} dev_state_e;

   dev_state_e          state_q, state_d;
   logic [1:0]          div_q;
   logic [WAIT_W-1:0]   wait_q;
   logic                dir_q;
   logic                ext_q;
   logic [1:0]          type_q;
   logic [BANK_W-1:0]   bank_q;
   logic                grant_n_q;
   logic                start;
   logic                tick;
   logic                ext_d;
   logic [WAIT_W-1:0]   wait_init;

   // a new cycle is ours only with request low and chip select high
   assign start = (state_q == ST_IDLE) && !bus.io_cycle_request_n && bus.chip_select;
   assign ext_d = (state_q == ST_IDLE) ? (bus.bank_code != BANK_INTERNAL) : ext_q;
   // synchronous cycles only count on whole divided-clock periods
   assign tick  = (type_q != TYPE_SYNC) || (div_q == DIV_LAST);

   // strobe length for each speed type
   always_comb begin
      case (bus.cycle_speed_type)
         TYPE_SLOW:   wait_init = WAIT_SLOW;
         TYPE_MEDIUM: wait_init = WAIT_MEDIUM;
         TYPE_FAST:   wait_init = WAIT_FAST;
         TYPE_SYNC:   wait_init = WAIT_SYNC;
         default:     wait_init = WAIT_SLOW;
      endcase
   end

   // next state of the cycle sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start) begin
               state_d = ext_d ? ST_EXT : ST_INT;
            end
         end
         ST_INT:  state_d = ST_GRANT;
         ST_EXT: begin
            if (tick && wait_q == '0) begin
               state_d = ST_GRANT;
            end
         end
         ST_GRANT: begin
            // grant low at this edge closes the cycle; the request level is not looked at
            state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // sequencer state
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else if (state_q != ST_GRANT || !grant_n_q) begin
         state_q <= state_d;
      end
   end

   // divide-by-four counter; its top bit is the peripheral timing clock
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_q <= RST_DIV;
      end else begin
         div_q <= div_q + 2'h1;
      end
   end
   assign clk_div4_o  = div_q[1];
   // inverted reference clock cannot come from a flop running on that same clock
   assign sys_clk_n_o = ~ref_clk_i;

   // capture the cycle attributes when the cycle is taken
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dir_q       <= DIR_READ;
         ext_q       <= 1'b0;
         type_q      <= TYPE_SLOW;
         bank_q      <= BANK_INTERNAL;
         reg_index_o <= '0;
         reg_wdata_o <= RST_DATA;
      end else if (start) begin
         dir_q       <= bus.read_write_n;
         ext_q       <= ext_d;
         type_q      <= bus.cycle_speed_type;
         bank_q      <= bus.bank_code;
         reg_index_o <= bus.register_index;
         reg_wdata_o <= bus.host_data;
      end
   end

   // strobe length counter
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= '0;
      end else if (start) begin
         wait_q <= wait_init;
      end else if (state_q == ST_EXT && tick && wait_q != '0) begin
         wait_q <= wait_q - 4'h1;
      end
   end

   // internal register strobes: one cycle, in the cycle after the request is taken
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_read_o  <= 1'b0;
         reg_write_o <= 1'b0;
      end else begin
         reg_read_o  <= start && !ext_d && bus.read_write_n == DIR_READ;
         reg_write_o <= start && !ext_d && bus.read_write_n == DIR_WRITE;
      end
   end

   // grant handshake; low for exactly one cycle, whatever the request does
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         grant_n_q <= 1'b1;
      end else if (state_q != ST_GRANT && state_d == ST_GRANT) begin
         grant_n_q <= 1'b0;
      end else if (state_q == ST_GRANT && !grant_n_q) begin
         grant_n_q <= 1'b1;
      end
   end
   assign bus.io_cycle_grant_n = grant_n_q;

   // host data lines carry read data only while the grant is out
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus.host_data_dev    <= RST_DATA;
         bus.host_data_dev_oe <= 1'b0;
      end else begin
         bus.host_data_dev    <= (state_q == ST_INT) ? reg_rdata_i : periph_data_i;
         bus.host_data_dev_oe <= state_d == ST_GRANT && state_q != ST_GRANT && dir_q == DIR_READ;
      end
   end

   // buffer enables follow any io cycle, whether or not this chip is selected
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         read_buffer_en_n_o  <= 1'b1;
         write_buffer_en_n_o <= 1'b1;
      end else begin
         read_buffer_en_n_o  <= !(!bus.io_cycle_request_n && bus.read_write_n == DIR_READ);
         write_buffer_en_n_o <= !(!bus.io_cycle_request_n && bus.read_write_n == DIR_WRITE);
      end
   end

   // external access controls: buffer select, bank select, latch, strobes, write data
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ext_buffer_select_n_o   <= 1'b1;
         peripheral_select_n_o   <= RST_SELECTS;
         data_latch_hold_n_o     <= 1'b1;
         periph_read_strobe_n_o  <= 1'b1;
         periph_write_strobe_n_o <= 1'b1;
         periph_data_o           <= RST_DATA;
         periph_data_oe_o        <= 1'b0;
      end else begin
         // outputs settle from the next state so that they line up with it
         ext_buffer_select_n_o   <= !(state_d == ST_EXT);
         peripheral_select_n_o   <= RST_SELECTS;
         if (state_d == ST_EXT) begin
            peripheral_select_n_o[ext_d ? bank_sel(start, bus.bank_code, bank_q) : 3'h0] <= 1'b0;
         end
         // latch stays transparent unless an external access holds the data
         data_latch_hold_n_o     <= !(ext_d && (state_d == ST_EXT || state_d == ST_GRANT));
         periph_read_strobe_n_o  <= !(state_d == ST_EXT && next_dir(start) == DIR_READ);
         periph_write_strobe_n_o <= !(state_d == ST_EXT && next_dir(start) == DIR_WRITE);
         if (start) begin
            periph_data_o <= bus.host_data;
         end
         periph_data_oe_o        <= state_d == ST_EXT && next_dir(start) == DIR_WRITE;
      end
   end

   // bank to select index: bank n drives line n-1
   function automatic logic [2:0] bank_sel(input logic s, input logic [2:0] b_in, input logic [2:0] b_q);
      logic [2:0] b;
      b = s ? b_in : b_q;
      return b - 3'h1;
   endfunction

   // direction of the cycle that the next state belongs to
   function automatic logic next_dir(input logic s);
      return s ? bus.read_write_n : dir_q;
   endfunction
endmodule

// *** hdl/io_cycle_requester.sv ***
// requester end: issues io cycles from a command port and buffers read data
`timescale 1ns/1ps
module io_cycle_requester
   import io_bus_pkg::*;
#(
   parameter int unsigned WIDTH = DATA_W,
   parameter int unsigned DEPTH = RSP_DEPTH
)
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   // link to the io controller
   io_bus_if.requester              bus,
   // command port
   input  wire logic                cmd_valid_i,
   output logic                     cmd_ready_o,
   input  wire logic                cmd_write_i,
   input  wire logic                cmd_chip_select_i,
   input  wire logic [1:0]          cmd_speed_type_i,
   input  wire logic [BANK_W-1:0]   cmd_bank_i,
   input  wire logic [INDEX_W-1:0]  cmd_index_i,
   input  wire logic [WIDTH-1:0]    cmd_wdata_i,
   // read data port
   output logic                     rsp_valid_o,
   input  wire logic                rsp_ready_i,
   output logic [WIDTH-1:0]         rsp_data_o
);
   typedef enum logic {RQ_IDLE, RQ_BUSY} req_state_e;

   localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   req_state_e          state_q;
   logic [WIDTH-1:0]    mem_q [DEPTH];
   logic [PTR_W-1:0]    wr_ptr_q;
   logic [PTR_W-1:0]    rd_ptr_q;
   logic [PTR_W:0]      count_q;
   logic                full;
   logic                take;
   logic                done;
   logic                push;
   logic                pop;

   assign full = count_q == (PTR_W+1)'(DEPTH);
   // a read is only started when its answer has a place to go
   assign take = state_q == RQ_IDLE && cmd_valid_i && !(full && !cmd_write_i);
   assign done = state_q == RQ_BUSY && !bus.io_cycle_request_n && !bus.io_cycle_grant_n;
   assign push = done && bus.read_write_n == DIR_READ;
   assign pop  = rsp_valid_o && rsp_ready_i;

   // one cycle outstanding at a time
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= RQ_IDLE;
      end else if (take) begin
         state_q <= RQ_BUSY;
      end else if (done) begin
         state_q <= RQ_IDLE;
      end
   end

   // link drive: request low with attributes held until grant is seen
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus.io_cycle_request_n <= 1'b1;
         bus.read_write_n       <= DIR_READ;
         bus.chip_select        <= 1'b0;
         bus.cycle_speed_type   <= TYPE_SLOW;
         bus.bank_code          <= BANK_INTERNAL;
         bus.register_index     <= '0;
         bus.host_data_req      <= RST_DATA;
         bus.host_data_req_oe   <= 1'b0;
      end else if (take) begin
         bus.io_cycle_request_n <= 1'b0;
         bus.read_write_n       <= cmd_write_i;
         bus.chip_select        <= cmd_chip_select_i;
         bus.cycle_speed_type   <= cmd_speed_type_i;
         bus.bank_code          <= cmd_bank_i;
         bus.register_index     <= cmd_index_i;
         bus.host_data_req      <= cmd_wdata_i[DATA_W-1:0];
         bus.host_data_req_oe   <= cmd_write_i;
      end else if (done) begin
         bus.io_cycle_request_n <= 1'b1;
         bus.chip_select        <= 1'b0;
         bus.host_data_req_oe   <= 1'b0;
      end
   end

   // command accepted only in idle; registered so it can go low under a busy cycle
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cmd_ready_o <= 1'b0;
      end else begin
         cmd_ready_o <= (state_q == RQ_IDLE) && !take;
      end
   end

   // two-entry read data buffer; a stalled reader blocks further reads
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) begin
            wr_ptr_q <= (wr_ptr_q == PTR_W'(DEPTH-1)) ? '0 : wr_ptr_q + PTR_W'(1);
         end
         if (pop) begin
            rd_ptr_q <= (rd_ptr_q == PTR_W'(DEPTH-1)) ? '0 : rd_ptr_q + PTR_W'(1);
         end
         count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
      end
   end

   // buffer storage
   always_ff @(posedge ref_clk_i) begin
      if (push) begin
         mem_q[wr_ptr_q] <= WIDTH'(bus.host_data);
      end
   end

   // head of the buffer, registered onto the read data port
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
      end else begin
         rsp_valid_o <= (count_q - (PTR_W+1)'(pop)) != '0 || push;
         if (pop || !rsp_valid_o) begin
            rsp_data_o <= (count_q > (PTR_W+1)'(pop)) ? mem_q[pop ? rd_ptr_q + PTR_W'(1) : rd_ptr_q]
                                                      : WIDTH'(bus.host_data);
         end
      end
   end
endmodule

// *** verification/io_bus_cycle_interface_asserts.sv ***
// concurrent checks on the io cycle request/grant link
`timescale 1ns/1ps
module io_bus_cycle_interface_asserts
   import io_bus_pkg::*;
(
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                rst_i,
   // link signals
   input  wire logic                io_cycle_request_n,
   input  wire logic                io_cycle_grant_n,
   input  wire logic [1:0]          cycle_speed_type,
   input  wire logic                read_write_n,
   input  wire logic                chip_select,
   input  wire logic [BANK_W-1:0]   bank_code,
   input  wire logic [INDEX_W-1:0]  register_index,
   input  wire logic                host_data_dev_oe
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // handshake shape
   a_grant_needs_request: assert property (!io_cycle_grant_n |-> !io_cycle_request_n)
      else $error("grant low without a request");
   a_grant_single_cycle: assert property (!io_cycle_grant_n && !io_cycle_request_n |=> io_cycle_grant_n && io_cycle_request_n)
      else $error("cycle did not end after completion");
   a_grant_no_select: assert property (!chip_select |-> io_cycle_grant_n)
      else $error("grant while deselected");
   a_attrs_hold: assert property (!io_cycle_request_n && io_cycle_grant_n |=> $stable({cycle_speed_type, read_write_n, chip_select, bank_code, register_index}))
      else $error("cycle attributes moved mid cycle");
   // data lines are driven by the device only to return read data
   a_read_drive_only: assert property (host_data_dev_oe |-> !read_write_n && !io_cycle_request_n)
      else $error("device drove data outside a read");
   a_read_answer_data: assert property (!io_cycle_grant_n && !read_write_n |-> host_data_dev_oe)
      else $error("read granted without data");
   // grant timing per target and speed; the lower bound catches a wait that is skipped, except on sync cycles
   a_internal_no_wait: assert property ($fell(io_cycle_request_n) && chip_select && bank_code == BANK_INTERNAL |-> io_cycle_grant_n[*2] ##[1:3] !io_cycle_grant_n)
      else $error("internal grant timing");
   a_fast_wait: assert property ($fell(io_cycle_request_n) && chip_select && bank_code != BANK_INTERNAL && cycle_speed_type == TYPE_FAST |-> io_cycle_grant_n[*4] ##[1:4] !io_cycle_grant_n)
      else $error("fast grant timing");
   a_medium_wait: assert property ($fell(io_cycle_request_n) && chip_select && bank_code != BANK_INTERNAL && cycle_speed_type == TYPE_MEDIUM |-> io_cycle_grant_n[*6] ##[2:6] !io_cycle_grant_n)
      else $error("medium grant timing");
   a_slow_wait: assert property ($fell(io_cycle_request_n) && chip_select && bank_code != BANK_INTERNAL && cycle_speed_type == TYPE_SLOW |-> io_cycle_grant_n[*8] ##[4:9] !io_cycle_grant_n)
      else $error("slow grant timing");
   a_sync_wait: assert property ($fell(io_cycle_request_n) && chip_select && bank_code != BANK_INTERNAL && cycle_speed_type == TYPE_SYNC |-> io_cycle_grant_n ##[1:10] !io_cycle_grant_n)
      else $error("sync grant timing");
endmodule

// *** verification/tb_io_bus_cycle_interface.sv ***
// self-checking bench: requester and io controller joined over the link
`timescale 1ns/1ps
module tb_io_bus_cycle_interface;
   import io_bus_pkg::*;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       cmd_valid = 1'b0, cmd_write = 1'b0, rsp_ready = 1'b1, cmd_cs = 1'b1;
   logic [1:0] cmd_type = 2'h0;
   logic [2:0] cmd_bank = 3'h0;
   logic [4:0] cmd_index = 5'h00, ridx, seen_idx;
   logic [7:0] cmd_wdata = 8'h00, periph_rdata = 8'h00, reg_rdata = 8'h00, rsp_data, pdata, rwdata, seen_wd;
   logic       cmd_ready, rsp_valid, div4, sys_n, lat_n, ext_n, rbuf_n, wbuf_n, rstb_n, we_n, pdoe, rrd, rwr;
   logic [6:0] sel_n, seen_sel;
   logic       seen_lat, seen_ext, seen_rstb, seen_we, seen_rbuf, seen_wbuf, seen_rrd, seen_rwr, seen_oe;
   logic [7:0] exp_q[$];
   int         mismatches = 0;
   int         tests_run = 0;
   // link and both ends
   io_bus_if io_bus_if_i ();
   io_cycle_device io_cycle_device_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(io_bus_if_i.device),
      .clk_div4_o(div4), .sys_clk_n_o(sys_n), .data_latch_hold_n_o(lat_n), .ext_buffer_select_n_o(ext_n),
      .read_buffer_en_n_o(rbuf_n), .write_buffer_en_n_o(wbuf_n), .peripheral_select_n_o(sel_n),
      .periph_read_strobe_n_o(rstb_n), .periph_write_strobe_n_o(we_n), .periph_data_i(periph_rdata),
      .periph_data_o(pdata), .periph_data_oe_o(pdoe), .reg_index_o(ridx), .reg_read_o(rrd),
      .reg_write_o(rwr), .reg_wdata_o(rwdata), .reg_rdata_i(reg_rdata));
   io_cycle_requester io_cycle_requester_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus(io_bus_if_i.requester),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_write_i(cmd_write), .cmd_chip_select_i(cmd_cs),
      .cmd_speed_type_i(cmd_type), .cmd_bank_i(cmd_bank), .cmd_index_i(cmd_index), .cmd_wdata_i(cmd_wdata),
      .rsp_valid_o(rsp_valid), .rsp_ready_i(rsp_ready), .rsp_data_o(rsp_data));
   io_bus_cycle_interface_asserts io_bus_cycle_interface_asserts_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .io_cycle_request_n(io_bus_if_i.io_cycle_request_n), .io_cycle_grant_n(io_bus_if_i.io_cycle_grant_n),
      .cycle_speed_type(io_bus_if_i.cycle_speed_type), .read_write_n(io_bus_if_i.read_write_n),
      .chip_select(io_bus_if_i.chip_select), .bank_code(io_bus_if_i.bank_code),
      .register_index(io_bus_if_i.register_index), .host_data_dev_oe(io_bus_if_i.host_data_dev_oe));
   always #20 ref_clk_i = ~ref_clk_i;
   // sticky record of what the device showed during one cycle
   always @(posedge ref_clk_i) begin
      seen_sel <= seen_sel | ~sel_n;
      seen_lat <= seen_lat | ~lat_n;
      seen_ext <= seen_ext | ~ext_n;
      seen_rstb <= seen_rstb | ~rstb_n;
      seen_we   <= seen_we | ~we_n;
      seen_rbuf <= seen_rbuf | ~rbuf_n;
      seen_wbuf <= seen_wbuf | ~wbuf_n;
      seen_oe   <= seen_oe | pdoe;
      seen_rrd <= seen_rrd | rrd;
      seen_rwr <= seen_rwr | rwr;
      if (rrd | rwr) seen_idx <= ridx;
      if (rwr) seen_wd <= rwdata;
      if (!we_n) seen_wd <= pdata;
   end
   task automatic check_bit(input string what, input logic exp, input logic got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_vec(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // one hot low select expected for a peripheral bank, none for bank zero
   function automatic logic [6:0] exp_sel(input logic [2:0] b);
      return (b == BANK_INTERNAL) ? 7'h00 : 7'(1 << (b - 1));
   endfunction
   // pops one read result; ready is high, so the word is taken at the next edge
   task automatic get_rsp();
      int i;
      i = 0;
      @(negedge ref_clk_i);
      while (rsp_valid !== 1'b1 && i < 20) begin
         @(negedge ref_clk_i);
         i++;
      end
      check_vec("read data", exp_q.pop_front(), rsp_data);
      @(posedge ref_clk_i);
   endtask
   task automatic run_cmd(input logic w, input logic [1:0] t, input logic [2:0] b, input logic [4:0] x,
                          input logic [7:0] d);
      logic       ext;
      logic [7:0] pr, rr;
      int         i;
      ext = (b != BANK_INTERNAL);
      pr = 8'($urandom);
      rr = 8'($urandom);
      @(negedge ref_clk_i);
      {seen_sel, seen_lat, seen_ext, seen_rstb, seen_we, seen_rbuf, seen_wbuf, seen_rrd, seen_rwr, seen_oe} <= '0;
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      {cmd_write, cmd_type, cmd_bank, cmd_index, cmd_wdata} <= {w, t, b, x, d};
      {periph_rdata, reg_rdata} <= {pr, rr};
      // valid is held until the cycle shows on the link, so the command cannot be taken twice
      for (i = 0; i < 40 && io_bus_if_i.io_cycle_request_n !== 1'b0; i++) @(negedge ref_clk_i);
      check_bit("cycle start", 1'b0, io_bus_if_i.io_cycle_request_n);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      for (i = 0; i < 40 && io_bus_if_i.io_cycle_grant_n !== 1'b0; i++) @(negedge ref_clk_i);
      check_bit("grant", 1'b0, io_bus_if_i.io_cycle_grant_n);
      @(posedge ref_clk_i);
      if (!w) exp_q.push_back(ext ? pr : rr);
      if (!w && rsp_ready) get_rsp();
      repeat (2) @(negedge ref_clk_i);
      check_bit("latch hold", ext, seen_lat);
      check_bit("ext select", ext, seen_ext);
      check_vec("selects", {1'b0, exp_sel(b)}, {1'b0, seen_sel});
      check_bit("read strobe", ext & ~w, seen_rstb);
      check_bit("write strobe", ext & w, seen_we);
      check_bit("periph drive", ext & w, seen_oe);
      check_bit("read buffer", ~w, seen_rbuf);
      check_bit("write buffer", w, seen_wbuf);
      check_bit("reg read", ~ext & ~w, seen_rrd);
      check_bit("reg write", ~ext & w, seen_rwr);
      if (!ext) check_vec("reg index", {3'h0, x}, {3'h0, seen_idx});
      if (w) check_vec("write data", d, seen_wd);
      check_vec("idle selects", {1'b1, RST_SELECTS}, {1'b1, sel_n});
      check_bit("ready again", 1'b1, cmd_ready);
   endtask
   // watchdog: the run needs about a thousand cycles, this allows ten thousand
   initial begin
      #400_000;
      mismatches++;
      test_done();
   end
   initial begin
      logic v0;
      void'($urandom(32'h03F5A2DF));
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (2) @(negedge ref_clk_i);
      // divided clock toggles every second reference period
      v0 = div4;
      repeat (2) @(negedge ref_clk_i);
      check_bit("div4 half", ~v0, div4);
      repeat (2) @(negedge ref_clk_i);
      check_bit("div4 period", v0, div4);
      check_bit("sys clock low", 1'b1, sys_n);
      @(posedge ref_clk_i);
      #5;
      check_bit("sys clock high", 1'b0, sys_n);
      // every speed code against every bank, random direction
      for (int t = 0; t < 4; t++) begin
         for (int b = 0; b < 8; b++) begin
            run_cmd(($urandom % 2) != 0, 2'(t), 3'(b), 5'($urandom), 8'($urandom));
         end
      end
      // index boundaries, back to back write then read
      run_cmd(1'b1, TYPE_FAST, BANK_INTERNAL, 5'h1F, 8'hA5);
      run_cmd(1'b0, TYPE_FAST, BANK_INTERNAL, 5'h00, 8'h00);
      run_cmd(1'b1, TYPE_SYNC, 3'h7, 5'h1F, 8'hFF);
      for (int n = 0; n < 20; n++) begin
         run_cmd(($urandom % 2) != 0, 2'($urandom), 3'($urandom), 5'($urandom), 8'($urandom));
      end
      // stalled reader: two results fill the buffer, a third read is held back
      @(posedge ref_clk_i);
      rsp_ready <= 1'b0;
      run_cmd(1'b0, TYPE_SYNC, BANK_INTERNAL, 5'h0A, 8'h00);
      run_cmd(1'b0, TYPE_MEDIUM, 3'h5, 5'h03, 8'h00);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      repeat (20) @(negedge ref_clk_i);
      check_bit("held while full", 1'b1, io_bus_if_i.io_cycle_request_n);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      rsp_ready <= 1'b1;
      get_rsp();
      get_rsp();
      // deselected read: no grant, read buffer follows, latch open
      @(posedge ref_clk_i);
      {cmd_cs, cmd_valid} <= 2'b01;
      repeat (4) @(negedge ref_clk_i);
      check_bit("no grant", 1'b1, io_bus_if_i.io_cycle_grant_n);
      check_bit("deselected rbuf", 1'b0, rbuf_n);
      check_bit("deselected latch", 1'b1, lat_n);
      test_done();
   end
endmodule
